// ---- hdl/vcc_map.svh ----
`ifndef VCC_MAP_SVH
`define VCC_MAP_SVH
// ==========================================================
// register addresses
`define VCC_CTRL_ADDR      8'h9b
`define VCC_MODE_ADDR      8'h9d
`define VCC_MUX_ADDR       8'h9f
// ==========================================================
// reset values
`define VCC_CTRL_RST       8'h00
`define VCC_MODE_RST       8'h02
`define VCC_MUX_RST        8'h00
// ==========================================================
// control register fields
`define VCC_CTRL_EN_BIT    7
`define VCC_CTRL_OUT_BIT   6
`define VCC_CTRL_RF_BIT    5
`define VCC_CTRL_FF_BIT    4
`define VCC_CTRL_HYP_HI    3
`define VCC_CTRL_HYP_LO    2
`define VCC_CTRL_HYN_HI    1
`define VCC_CTRL_HYN_LO    0
// ==========================================================
// mode register fields
`define VCC_MODE_RIE_BIT   5
`define VCC_MODE_FIE_BIT   4
`define VCC_MODE_RM_HI     1
`define VCC_MODE_RM_LO     0
`define VCC_MODE_WMASK     8'h33
// ==========================================================
// mux register fields
`define VCC_MUX_N_HI       6
`define VCC_MUX_N_LO       4
`define VCC_MUX_P_HI       2
`define VCC_MUX_P_LO       0
`define VCC_MUX_WMASK      8'h77
`endif

// ---- hdl/vcc_pkg.sv ----
package vcc_pkg;
   // ==========================================================
   // trims handed to the analog core
   typedef struct packed {
      logic       power_on;
      logic [1:0] pos_hyst_sel;
      logic [1:0] neg_hyst_sel;
      logic [1:0] response_mode;
      logic [2:0] pos_input_sel;
      logic [2:0] neg_input_sel;
   } vcc_analog_s;
   // ==========================================================
   // register bus request
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } vcc_bus_s;
endpackage

// ---- hdl/vcc_sync.sv ----
`timescale 1ns/1ps
module vcc_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             ref_clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] d,
   output      logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] meta_next;
   logic [WIDTH-1:0] q_next;

   // ==========================================================
   // two-stage synchroniser
   always_comb begin
      meta_next = d;
      q_next    = meta_reg;
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         meta_reg <= '0;
         q        <= '0;
      end else begin
         meta_reg <= meta_next;
         q        <= q_next;
      end
   end
endmodule

// ---- hdl/vcc_top.sv ----
// Summary of operation
// - control bit 7 turns the comparator on when 1 and off when 0.
// - while disabled, the latched and raw outputs are low and comparator power is off.
// - control bit 6 reads the live result, 1 when plus exceeds minus.
// - a rising output edge sets the rising flag in control bit 5.
// - a falling output edge sets the falling flag in control bit 4.
// - edge flags stay set until software writes them to zero.
// - the rising interrupt passes only when mode bit 5 is 1.
// - the falling interrupt passes only when mode bit 4 is 1.
// - control bits 3:2 select positive hysteresis off, 5, 10, 20 mV.
// - control bits 1:0 select negative hysteresis off, 5, 10, 20 mV.
// - mode bits 1:0 select response from fastest to lowest power.
// - a clocked latched output and a raw asynchronous output exist.
// - mode bits 7:6 and 3:2 read zero and ignore writes.
// - mux fields route the positive and negative comparator inputs.
`timescale 1ns/1ps
`include "vcc_map.svh"
module vcc_top (
   input  wire logic                 ref_clk,
   input  wire logic                 rst,
   input  wire logic                 bus_wr,
   input  wire logic                 bus_rd,
   input  wire logic [7:0]           bus_addr,
   input  wire logic [7:0]           bus_wdata,
   output      logic [7:0]           bus_rdata,
   input  wire logic                 cmp_raw,
   output      vcc_pkg::vcc_analog_s analog_ctrl,
   output      logic                 latched_output,
   output      logic                 raw_async_output,
   output      logic                 cmp_irq
);
   logic [7:0]           ctrl_reg;
   logic [7:0]           ctrl_next;
   logic [7:0]           mode_reg;
   logic [7:0]           mode_next;
   logic [7:0]           mux_reg;
   logic [7:0]           mux_next;
   logic [7:0]           rdata_next;
   logic                 prev_reg;
   logic                 prev_next;
   logic                 latched_next;
   logic                 irq_next;
   logic                 cmp_sync;
   logic                 rise_ev;
   logic                 fall_ev;
   logic                 cmp_enable;
   vcc_pkg::vcc_analog_s analog_next;
   vcc_pkg::vcc_bus_s    bus;

   assign bus = '{wr: bus_wr, rd: bus_rd, addr: bus_addr,
                  wdata: bus_wdata};
   assign cmp_enable = ctrl_reg[`VCC_CTRL_EN_BIT];

   // ==========================================================
   // synchroniser
   vcc_sync #(.WIDTH(1)) u_sync (
      .ref_clk (ref_clk),
      .rst     (rst),
      .d       (cmp_raw),
      .q       (cmp_sync)
   );

   // ==========================================================
   // edge detection
   always_comb begin
      prev_next = cmp_sync;
      rise_ev   = cmp_enable & cmp_sync & ~prev_reg;
      fall_ev   = cmp_enable & ~cmp_sync & prev_reg;
   end

   // ==========================================================
   // registers
   always_comb begin
      ctrl_next = ctrl_reg;
      mode_next = mode_reg;
      mux_next  = mux_reg;
      if (bus.wr && bus.addr == `VCC_CTRL_ADDR) begin
         ctrl_next = bus.wdata;
      end
      if (bus.wr && bus.addr == `VCC_MODE_ADDR) begin
         mode_next = bus.wdata & `VCC_MODE_WMASK;
      end
      if (bus.wr && bus.addr == `VCC_MUX_ADDR) begin
         mux_next = bus.wdata & `VCC_MUX_WMASK;
      end
      ctrl_next[`VCC_CTRL_OUT_BIT] = 1'b0;
      // hardware sets win over software clear
      if (rise_ev) begin
         ctrl_next[`VCC_CTRL_RF_BIT] = 1'b1;
      end
      if (fall_ev) begin
         ctrl_next[`VCC_CTRL_FF_BIT] = 1'b1;
      end
   end

   // ==========================================================
   // read data and outputs
   always_comb begin
      unique case (bus.addr)
         `VCC_CTRL_ADDR: rdata_next = ctrl_reg
            | ({7'h00, cmp_sync & cmp_enable} << `VCC_CTRL_OUT_BIT);
         `VCC_MODE_ADDR: rdata_next = mode_reg;
         `VCC_MUX_ADDR:  rdata_next = mux_reg;
         default:        rdata_next = 8'h00;
      endcase
      if (!bus.rd) begin
         rdata_next = 8'h00;
      end
      analog_next.power_on      =
         ctrl_next[`VCC_CTRL_EN_BIT];
      analog_next.pos_hyst_sel  =
         ctrl_next[`VCC_CTRL_HYP_HI:`VCC_CTRL_HYP_LO];
      analog_next.neg_hyst_sel  =
         ctrl_next[`VCC_CTRL_HYN_HI:`VCC_CTRL_HYN_LO];
      analog_next.response_mode =
         mode_next[`VCC_MODE_RM_HI:`VCC_MODE_RM_LO];
      analog_next.pos_input_sel =
         mux_next[`VCC_MUX_P_HI:`VCC_MUX_P_LO];
      analog_next.neg_input_sel =
         mux_next[`VCC_MUX_N_HI:`VCC_MUX_N_LO];
      latched_next =
         cmp_sync & ctrl_next[`VCC_CTRL_EN_BIT];
      irq_next =
         (ctrl_next[`VCC_CTRL_RF_BIT] & mode_next[`VCC_MODE_RIE_BIT])
         | (ctrl_next[`VCC_CTRL_FF_BIT]
            & mode_next[`VCC_MODE_FIE_BIT]);
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ctrl_reg       <= `VCC_CTRL_RST;
         mode_reg       <= `VCC_MODE_RST;
         mux_reg        <= `VCC_MUX_RST;
         prev_reg       <= 1'b0;
         bus_rdata      <= 8'h00;
         analog_ctrl    <= '0;
         latched_output <= 1'b0;
         cmp_irq        <= 1'b0;
      end else begin
         ctrl_reg       <= ctrl_next;
         mode_reg       <= mode_next;
         mux_reg        <= mux_next;
         prev_reg       <= prev_next;
         bus_rdata      <= rdata_next;
         analog_ctrl    <= analog_next;
         latched_output <= latched_next;
         cmp_irq        <= irq_next;
      end
   end

   // ==========================================================
   // raw output: pure gate of the analog result, works without clock
   always_comb begin
      raw_async_output = cmp_raw & cmp_enable;
   end

   // ==========================================================
   // assertions
   AST_RISE_SETS: assert property (
      @(posedge ref_clk) disable iff (rst)
      rise_ev |=> ctrl_reg[`VCC_CTRL_RF_BIT])
      else $error("rising edge did not set flag");
   AST_FALL_SETS: assert property (
      @(posedge ref_clk) disable iff (rst)
      fall_ev |=> ctrl_reg[`VCC_CTRL_FF_BIT])
      else $error("falling edge did not set flag");
   AST_FLAG_HOLD: assert property (
      @(posedge ref_clk) disable iff (rst)
      (ctrl_reg[`VCC_CTRL_RF_BIT]
       && !(bus_wr && bus_addr == `VCC_CTRL_ADDR))
      |=> ctrl_reg[`VCC_CTRL_RF_BIT])
      else $error("rising flag cleared without write");
   AST_FALL_HOLD: assert property (
      @(posedge ref_clk) disable iff (rst)
      (ctrl_reg[`VCC_CTRL_FF_BIT]
       && !(bus_wr && bus_addr == `VCC_CTRL_ADDR))
      |=> ctrl_reg[`VCC_CTRL_FF_BIT])
      else $error("falling flag cleared without write");
   AST_IRQ: assert property (
      @(posedge ref_clk) disable iff (rst)
      cmp_irq == ((ctrl_reg[`VCC_CTRL_RF_BIT]
                   && mode_reg[`VCC_MODE_RIE_BIT])
                  || (ctrl_reg[`VCC_CTRL_FF_BIT]
                      && mode_reg[`VCC_MODE_FIE_BIT])))
      else $error("interrupt does not match flags and enables");
   AST_RIE_GATE: assert property (
      @(posedge ref_clk) disable iff (rst)
      (!mode_reg[`VCC_MODE_RIE_BIT]
       && !(ctrl_reg[`VCC_CTRL_FF_BIT] && mode_reg[`VCC_MODE_FIE_BIT]))
      |-> !cmp_irq)
      else $error("rising interrupt passed while disabled");
   AST_FIE_GATE: assert property (
      @(posedge ref_clk) disable iff (rst)
      (!mode_reg[`VCC_MODE_FIE_BIT]
       && !(ctrl_reg[`VCC_CTRL_RF_BIT] && mode_reg[`VCC_MODE_RIE_BIT]))
      |-> !cmp_irq)
      else $error("falling interrupt passed while disabled");
   AST_MODE_ZERO: assert property (
      @(posedge ref_clk) disable iff (rst)
      (mode_reg & ~`VCC_MODE_WMASK) == 8'h00)
      else $error("unused mode bits set");
   AST_OFF_LOW: assert property (
      @(posedge ref_clk) disable iff (rst)
      !cmp_enable |-> !latched_output)
      else $error("latched output high while disabled");
   AST_RAW_OFF: assert property (
      @(posedge ref_clk) disable iff (rst)
      !cmp_enable |-> !raw_async_output)
      else $error("raw output high while disabled");
   AST_POWER: assert property (
      @(posedge ref_clk) disable iff (rst)
      (bus_wr && bus_addr == `VCC_CTRL_ADDR)
      |=> analog_ctrl.power_on == $past(bus_wdata[`VCC_CTRL_EN_BIT]))
      else $error("power does not follow enable write");
   AST_HYST: assert property (
      @(posedge ref_clk) disable iff (rst)
      (bus_wr && bus_addr == `VCC_CTRL_ADDR)
      |=> {analog_ctrl.pos_hyst_sel, analog_ctrl.neg_hyst_sel}
          == $past(bus_wdata[`VCC_CTRL_HYP_HI:`VCC_CTRL_HYN_LO]))
      else $error("hysteresis trims do not follow write");
   AST_MODE_TRIM: assert property (
      @(posedge ref_clk) disable iff (rst)
      (bus_wr && bus_addr == `VCC_MODE_ADDR)
      |=> analog_ctrl.response_mode
          == $past(bus_wdata[`VCC_MODE_RM_HI:`VCC_MODE_RM_LO]))
      else $error("response mode does not follow write");
   AST_MUX_SEL: assert property (
      @(posedge ref_clk) disable iff (rst)
      (bus_wr && bus_addr == `VCC_MUX_ADDR)
      |=> analog_ctrl.pos_input_sel
          == $past(bus_wdata[`VCC_MUX_P_HI:`VCC_MUX_P_LO])
          && analog_ctrl.neg_input_sel
          == $past(bus_wdata[`VCC_MUX_N_HI:`VCC_MUX_N_LO]))
      else $error("input selects do not follow write");
   AST_LATCH_SYNC: assert property (
      @(posedge ref_clk) disable iff (rst)
      cmp_enable |-> latched_output == $past(cmp_sync))
      else $error("latched output does not follow synchronised result");
   AST_OUT_READ: assert property (
      @(posedge ref_clk) disable iff (rst)
      (bus_rd && bus_addr == `VCC_CTRL_ADDR && cmp_enable && cmp_sync)
      |=> bus_rdata[`VCC_CTRL_OUT_BIT])
      else $error("result bit not read");

   // ==========================================================
   // coverage of main scenarios
   COV_RISE: cover property (@(posedge ref_clk) rise_ev);
   COV_FALL: cover property (@(posedge ref_clk) fall_ev);
   COV_IRQ:  cover property (@(posedge ref_clk) $rose(cmp_irq));
   COV_BOTH: cover property (@(posedge ref_clk)
      ctrl_reg[`VCC_CTRL_RF_BIT] && ctrl_reg[`VCC_CTRL_FF_BIT]);
   COV_OFF:  cover property (@(posedge ref_clk) $fell(cmp_enable));
endmodule

// ---- verif/vcc_cmp_model.sv ----
`timescale 1ns/1ps
// ==========================================================
// analog core: follows level while powered, noise while off
module vcc_cmp_model (
   input  wire logic                 ref_clk,
   input  wire vcc_pkg::vcc_analog_s analog_ctrl,
   input  wire logic                 level,
   output      logic                 cmp_raw
);
   logic noise_reg = 1'b0;
   always @(posedge ref_clk) noise_reg <= ~noise_reg;
   assign cmp_raw = analog_ctrl.power_on ? level : noise_reg;
endmodule

// ---- verif/tb.sv ----
`timescale 1ns/1ps
`include "vcc_map.svh"
module tb;
   logic                 ref_clk   = 1'b0;
   logic                 rst       = 1'b1;
   logic                 bus_wr    = 1'b0;
   logic                 bus_rd    = 1'b0;
   logic [7:0]           bus_addr  = 8'h00;
   logic [7:0]           bus_wdata = 8'h00;
   logic                 level     = 1'b0;
   logic [7:0]           bus_rdata;
   logic                 cmp_raw;
   logic                 latched_output;
   logic                 raw_async_output;
   logic                 cmp_irq;
   logic [7:0]           outs;
   vcc_pkg::vcc_analog_s analog_ctrl;
   int                   fails     = 0;
   int                   checked   = 0;
   assign outs = {5'h00, latched_output, raw_async_output, cmp_irq};
   // ==========================================================
   // design and analog core
   vcc_top dut (.ref_clk(ref_clk), .rst(rst), .bus_wr(bus_wr),
      .bus_rd(bus_rd), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
      .bus_rdata(bus_rdata), .cmp_raw(cmp_raw),
      .analog_ctrl(analog_ctrl), .latched_output(latched_output),
      .raw_async_output(raw_async_output), .cmp_irq(cmp_irq));
   vcc_cmp_model core (.ref_clk(ref_clk), .analog_ctrl(analog_ctrl),
      .level(level), .cmp_raw(cmp_raw));
   initial begin
      forever #2 ref_clk = ~ref_clk;
   end
   // ==========================================================
   // shared tasks
   task automatic conclude();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk) #1;
      bus_wr = 1'b1;
      bus_addr = a;
      bus_wdata = d;
      @(posedge ref_clk) #1;
      bus_wr = 1'b0;
      @(posedge ref_clk) #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge ref_clk) #1;
      bus_rd = 1'b1;
      bus_addr = a;
      @(posedge ref_clk) #1;
      bus_rd = 1'b0;
      chk(bus_rdata, exp);
   endtask
   task automatic settle(input logic exp);
      int n;
      n = 0;
      while (latched_output !== exp && n < 10) begin
         @(posedge ref_clk) #1;
         n++;
      end
      if (latched_output !== exp) begin
         fails++;
         $display("mismatch at %0t: latched output timed out", $time);
         disable scenarios;
      end
      repeat (2) @(posedge ref_clk);
      #1;
   endtask
   // ==========================================================
   // scenarios
   task automatic t_regs();
      int i;
      rd(`VCC_CTRL_ADDR, 8'h00);
      rd(`VCC_MODE_ADDR, 8'h02);
      rd(`VCC_MUX_ADDR, 8'h00);
      wr(`VCC_MODE_ADDR, 8'hff);
      rd(`VCC_MODE_ADDR, 8'h33);
      wr(8'h9c, 8'hff);
      rd(8'h9c, 8'h00);
      wr(`VCC_MUX_ADDR, 8'hf5);
      rd(`VCC_MUX_ADDR, 8'h75);
      chk({2'b00, analog_ctrl.pos_input_sel, analog_ctrl.neg_input_sel},
         8'h2f);
      for (i = 0; i < 4; i++) begin
         wr(`VCC_MODE_ADDR, i[7:0]);
         chk({6'h00, analog_ctrl.response_mode}, i[7:0]);
         wr(`VCC_CTRL_ADDR, {4'h0, i[1:0], ~i[1:0]});
         chk({6'h00, analog_ctrl.pos_hyst_sel}, i[7:0]);
         chk({6'h00, ~analog_ctrl.neg_hyst_sel}, i[7:0]);
      end
      $display("test regs done");
   endtask
   task automatic t_edges();
      wr(`VCC_CTRL_ADDR, 8'h80);
      chk({7'h00, analog_ctrl.power_on}, 8'h01);
      repeat (8) @(posedge ref_clk);
      wr(`VCC_CTRL_ADDR, 8'h80);
      rd(`VCC_CTRL_ADDR, 8'h80);
      wr(`VCC_MODE_ADDR, 8'h20);
      level = 1'b1;
      settle(1'b1);
      chk(outs, 8'h07);
      rd(`VCC_CTRL_ADDR, 8'he0);
      level = 1'b0;
      settle(1'b0);
      rd(`VCC_CTRL_ADDR, 8'hb0);
      chk(outs, 8'h01);
      wr(`VCC_CTRL_ADDR, 8'hd0);
      rd(`VCC_CTRL_ADDR, 8'h90);
      chk(outs, 8'h00);
      wr(`VCC_MODE_ADDR, 8'h10);
      chk(outs, 8'h01);
      wr(`VCC_CTRL_ADDR, 8'h80);
      chk(outs, 8'h00);
      wr(`VCC_MODE_ADDR, 8'h00);
      level = 1'b1;
      settle(1'b1);
      rd(`VCC_CTRL_ADDR, 8'he0);
      chk(outs, 8'h06);
      level = 1'b0;
      #1;
      chk(outs, 8'h04);
      $display("test edges done");
   endtask
   task automatic t_off();
      int i;
      wr(`VCC_CTRL_ADDR, 8'h00);
      for (i = 0; i < 6; i++) begin
         @(posedge ref_clk) #1;
         chk({analog_ctrl.power_on, outs[6:0]}, 8'h00);
      end
      $display("test off done");
   endtask
   initial begin
      repeat (3) @(posedge ref_clk);
      #1;
      rst = 1'b0;
      begin : scenarios
         t_regs();
         t_edges();
         t_off();
      end
      conclude();
   end
endmodule
